// >>> upf_dev.sv
// Functional notes
// RQ1: power enable low configured, high suspended
// RQ2: drive receive byte while read low
// RQ3: read falling edge advances receive buffer
// RQ4: write falling edge captures data byte
// RQ5: host writes only when room low
// RQ6: status pins released during reset
// RQ7: receive-available low when byte waiting
// RQ8: host reads only when available low
// RQ9: remote wakeup makes receive-available input
// RQ10: hold pin low 20 ms, resume
// RQ11: weak pull-down on inputs while suspended
// RQ12: use pull-down when power switching
// RQ13: external logic may reset device
// RQ14: release data bus while read high
`timescale 1ns/1ps
`default_nettype none
module upf_dev #(
  parameter int RX_DEPTH = upf_pkg::RX_DEPTH,
  parameter int TX_DEPTH = upf_pkg::TX_DEPTH,
  parameter int WAKE_CYC = upf_pkg::WAKE_CYC
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // pin side
  upf_if.dev pins,
  // usb engine side: bytes from host
  input wire logic [7:0] usb_rx_data,
  input wire logic usb_rx_valid,
  output logic usb_rx_ready,
  // usb engine side: bytes to host
  output logic [7:0] usb_tx_data,
  output logic usb_tx_valid,
  input wire logic usb_tx_ready,
  // usb link state and options
  input wire logic usb_configured,
  input wire logic usb_suspended,
  input wire logic opt_remote_wakeup,
  input wire logic opt_suspend_pulldown,
  output logic usb_resume_req
);
  localparam int RA = $clog2(RX_DEPTH);
  localparam int TA = $clog2(TX_DEPTH);
  initial begin
    if (RX_DEPTH < 2 || (1 << RA) != RX_DEPTH) $error("RX_DEPTH must be a power of two");
    if (TX_DEPTH < 2 || (1 << TA) != TX_DEPTH) $error("TX_DEPTH must be a power of two");
    if (WAKE_CYC < 1) $error("WAKE_CYC must be positive");
  end
  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [2:0] rd_s_q;
  logic [2:0] wr_s_q;
  logic [1:0] rxa_s_q;
  logic [7:0] d_s1_q;
  logic [7:0] d_s2_q;
  // two flops, third stage for edge detection
  always_ff @(posedge sys_clk) begin
    rd_s_q <= {rd_s_q[1:0], pins.rd_n};
    wr_s_q <= {wr_s_q[1:0], pins.wr};
    rxa_s_q <= {rxa_s_q[0], pins.rx_avail_n};
    d_s1_q <= pins.d;
    d_s2_q <= d_s1_q;
  end
  logic rd_low;
  logic rd_fall;
  logic wr_fall;
  assign rd_low = ~rd_s_q[1];
  assign rd_fall = rd_s_q[2] & ~rd_s_q[1];
  assign wr_fall = wr_s_q[2] & ~wr_s_q[1];
  // ****************************************
  // power enable and suspend state
  // ****************************************
  logic pwr_en_n_q;
  logic wake_mode;
  // low once configured, high in suspend
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pwr_en_n_q <= upf_pkg::PWR_EN_RST;
    end else begin
      pwr_en_n_q <= usb_suspended | ~usb_configured; // RQ1
    end
  end
  assign pins.power_enable_n = pwr_en_n_q;
  assign wake_mode = opt_remote_wakeup & usb_suspended & pwr_en_n_q; // RQ9
  logic pd_q;
  // weak pull-down of inputs while suspended
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pd_q <= 1'b0;
    end else begin
      pd_q <= opt_suspend_pulldown & usb_suspended; // RQ11
    end
  end
  assign pins.pull_down = pd_q;
  // ****************************************
  // receive buffer (usb to pins)
  // ****************************************
  logic [7:0] rx_mem [RX_DEPTH];
  logic [RA:0] rx_wp_q;
  logic [RA:0] rx_rp_q;
  logic rx_full;
  logic rx_empty;
  assign rx_full = (rx_wp_q[RA] != rx_rp_q[RA]) && (rx_wp_q[RA-1:0] == rx_rp_q[RA-1:0]);
  assign rx_empty = rx_wp_q == rx_rp_q;
  // write side from usb engine
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rx_wp_q <= '0;
    end else if (usb_rx_valid && !rx_full) begin
      rx_mem[rx_wp_q[RA-1:0]] <= usb_rx_data;
      rx_wp_q <= rx_wp_q + 1'b1;
    end
  end
  logic rx_head_q;
  // head byte shown; a read fall pops it and presents the next
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rx_rp_q <= '0;
      rx_head_q <= 1'b0;
    end else if (rd_fall) begin
      if (rx_head_q) begin
        rx_rp_q <= rx_rp_q + 1'b1; // RQ3
      end
      rx_head_q <= ~rx_empty && !(rx_head_q && (rx_wp_q == rx_rp_q + 1'b1));
    end else if (!rx_head_q && !rx_empty) begin
      rx_head_q <= 1'b1;
    end
  end
  assign usb_rx_ready = rst ? 1'b0 : ~rx_full;
  // ****************************************
  // data bus drive
  // ****************************************
  logic [7:0] dout_q;
  logic doe_q;
  // drive byte while read low, release otherwise
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      dout_q <= upf_pkg::DATA_RST;
      doe_q <= 1'b0;
    end else begin
      // hold the shown byte for the whole low phase, even after the pop
      dout_q <= rd_low ? dout_q : rx_mem[rx_rp_q[RA-1:0]]; // RQ2
      doe_q <= rd_low; // RQ14
    end
  end
  assign pins.dev_d_o = dout_q;
  assign pins.dev_d_oe = doe_q;
  // ****************************************
  // transmit buffer (pins to usb)
  // ****************************************
  logic [7:0] tx_mem [TX_DEPTH];
  logic [TA:0] tx_wp_q;
  logic [TA:0] tx_rp_q;
  logic tx_full;
  assign tx_full = (tx_wp_q[TA] != tx_rp_q[TA]) && (tx_wp_q[TA-1:0] == tx_rp_q[TA-1:0]);
  // capture bus on write falling edge
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tx_wp_q <= '0;
    end else if (wr_fall && !tx_full) begin
      tx_mem[tx_wp_q[TA-1:0]] <= d_s2_q; // RQ4
      tx_wp_q <= tx_wp_q + 1'b1;
    end
  end
  // drain to usb engine
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tx_rp_q <= '0;
    end else if (usb_tx_valid && usb_tx_ready) begin
      tx_rp_q <= tx_rp_q + 1'b1;
    end
  end
  assign usb_tx_valid = ~rst & (tx_wp_q != tx_rp_q);
  assign usb_tx_data = tx_mem[tx_rp_q[TA-1:0]];
  // ****************************************
  // status pins
  // ****************************************
  logic txr_q;
  logic txr_oe_q;
  logic rxa_q;
  logic rxa_oe_q;
  // released in reset, rx pin an input in wake mode
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      txr_q <= upf_pkg::STATUS_N_RST;
      txr_oe_q <= 1'b0; // RQ6
      rxa_q <= upf_pkg::STATUS_N_RST;
      rxa_oe_q <= 1'b0; // RQ6
    end else begin
      txr_q <= tx_full | (wr_s_q[1] ^ wr_s_q[2]);
      txr_oe_q <= 1'b1;
      rxa_q <= ~rx_head_q | rd_low | rd_s_q[2] ^ rd_s_q[1]; // RQ7
      rxa_oe_q <= ~wake_mode; // RQ9
    end
  end
  assign pins.tx_room_n_o = txr_q;
  assign pins.tx_room_n_oe = txr_oe_q;
  assign pins.rx_avail_n_o = rxa_q;
  assign pins.rx_avail_n_oe = rxa_oe_q;
  // ****************************************
  // remote wakeup detection
  // ****************************************
  logic [$clog2(WAKE_CYC+1)-1:0] wake_cnt_q;
  logic resume_q;
  // count low time on the rx pin while it is an input
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wake_cnt_q <= '0;
      resume_q <= 1'b0;
    end else begin
      resume_q <= 1'b0;
      if (!wake_mode || rxa_oe_q || rxa_s_q[1]) begin
        wake_cnt_q <= '0;
      end else if (wake_cnt_q == WAKE_CYC[$clog2(WAKE_CYC+1)-1:0] - 1'b1) begin
        resume_q <= 1'b1; // RQ10
        wake_cnt_q <= '0;
      end else begin
        wake_cnt_q <= wake_cnt_q + 1'b1;
      end
    end
  end
  assign usb_resume_req = resume_q;
endmodule
`default_nettype wire

// >>> upf_pkg.sv
package upf_pkg;
  // ****************************************
  // data path and timing
  // ****************************************
  localparam int DATA_W = 8;
  localparam int CLK_HZ = 50000000;
  localparam int WAKE_MIN_MS = 20;
  // least time, kHz rounded down: 20 ms at 50 MHz
  localparam int WAKE_CYC = (WAKE_MIN_MS * (CLK_HZ / 1000));
  localparam int RX_DEPTH = 128;
  localparam int TX_DEPTH = 256;
  // ****************************************
  // reset values of the pin outputs
  // ****************************************
  localparam logic PWR_EN_RST = 1'b1;
  localparam logic STATUS_N_RST = 1'b1;
  localparam logic [7:0] DATA_RST = 8'h00;
endpackage

// >>> upf_if.sv
`timescale 1ns/1ps
`default_nettype none
interface upf_if;
  // data bus, two signals per end and the resolved level
  logic [7:0] dev_d_o;
  logic dev_d_oe;
  logic [7:0] host_d_o;
  logic host_d_oe;
  logic [7:0] d;
  // strobes from the external logic
  logic rd_n;
  logic wr;
  // status pins
  logic tx_room_n_o;
  logic tx_room_n_oe;
  logic rx_avail_n_o;
  logic rx_avail_n_oe;
  logic host_rxa_o;
  logic host_rxa_oe;
  logic rx_avail_n;
  logic tx_room_n;
  logic power_enable_n;
  // device pull-down during suspend
  logic pull_down;
  // resolved wire levels; pull-up, data bus pulled low instead while pull-down active
  assign d = dev_d_oe ? dev_d_o : (host_d_oe ? host_d_o : {8{~pull_down}});
  assign rx_avail_n = rx_avail_n_oe ? rx_avail_n_o : (host_rxa_oe ? host_rxa_o : 1'b1);
  assign tx_room_n = tx_room_n_oe ? tx_room_n_o : 1'b1;
  modport dev (
    output dev_d_o, dev_d_oe, tx_room_n_o, tx_room_n_oe, rx_avail_n_o, rx_avail_n_oe,
    output power_enable_n, pull_down,
    input d, rd_n, wr, rx_avail_n
  );
  modport host (
    output host_d_o, host_d_oe, rd_n, wr, host_rxa_o, host_rxa_oe,
    input d, rx_avail_n, tx_room_n, power_enable_n
  );
endinterface
`default_nettype wire

// >>> upf_host.sv
`timescale 1ns/1ps
`default_nettype none
module upf_host #(
  parameter int STROBE_CYC = 4,
  parameter int WAKE_CYC = upf_pkg::WAKE_CYC
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // pin side
  upf_if.host pins,
  // user write request
  input wire logic [7:0] wr_data,
  input wire logic wr_valid,
  output logic wr_ready,
  // user read answer
  input wire logic rd_req,
  output logic [7:0] rd_data,
  output logic rd_valid,
  // user wake request
  input wire logic wake_req,
  output logic wake_busy
);
  initial begin
    if (STROBE_CYC < 4) $error("STROBE_CYC must cover the device synchroniser");
  end
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_WR_HI = 3'b001,
    ST_WR_LO = 3'b010,
    ST_RD_LO = 3'b011,
    ST_RD_HI = 3'b100,
    ST_WAKE = 3'b101
  } upf_state_e;
  upf_state_e st_q;
  logic [1:0] rxa_s_q;
  logic [1:0] txr_s_q;
  logic [1:0] pwr_s_q;
  logic [7:0] d_s1_q;
  logic [7:0] d_s2_q;
  // two-flop synchronisers of device pins
  always_ff @(posedge sys_clk) begin
    rxa_s_q <= {rxa_s_q[0], pins.rx_avail_n};
    txr_s_q <= {txr_s_q[0], pins.tx_room_n};
    pwr_s_q <= {pwr_s_q[0], pins.power_enable_n};
    d_s1_q <= pins.d;
    d_s2_q <= d_s1_q;
  end
  logic [31:0] cnt_q;
  logic rd_n_q;
  logic wr_q;
  logic [7:0] dq;
  logic doe_q;
  logic rxa_oe_q;
  logic rdv_q;
  logic [7:0] rdd_q;
  // strobe sequencer; reset state leaves device reset to the rst pin
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_q <= ST_IDLE;
      cnt_q <= '0;
      rd_n_q <= 1'b1;
      wr_q <= 1'b0;
      dq <= 8'h00;
      doe_q <= 1'b0;
      rxa_oe_q <= 1'b0;
      rdv_q <= 1'b0;
      rdd_q <= 8'h00;
    end else begin
      rdv_q <= 1'b0;
      cnt_q <= cnt_q + 1;
      case (st_q)
        ST_IDLE: begin
          cnt_q <= '0;
          if (wake_req && pwr_s_q[1]) begin
            rxa_oe_q <= 1'b1; // RQ10
            st_q <= ST_WAKE;
          end else if (wr_valid && !txr_s_q[1]) begin
            dq <= wr_data; // RQ5
            doe_q <= 1'b1;
            wr_q <= 1'b1;
            st_q <= ST_WR_HI;
          end else if (rd_req && !rxa_s_q[1]) begin
            rd_n_q <= 1'b0; // RQ8
            st_q <= ST_RD_LO;
          end
        end
        ST_WR_HI: begin
          if (cnt_q == STROBE_CYC - 1) begin
            wr_q <= 1'b0;
            cnt_q <= '0;
            st_q <= ST_WR_LO;
          end
        end
        ST_WR_LO: begin
          if (cnt_q == STROBE_CYC - 1) begin
            doe_q <= 1'b0;
            st_q <= ST_IDLE;
          end
        end
        ST_RD_LO: begin
          if (cnt_q == STROBE_CYC + 1) begin
            rdd_q <= d_s2_q;
            rdv_q <= 1'b1;
            rd_n_q <= 1'b1;
            cnt_q <= '0;
            st_q <= ST_RD_HI;
          end
        end
        ST_RD_HI: begin
          if (cnt_q == STROBE_CYC + 1) begin
            st_q <= ST_IDLE;
          end
        end
        ST_WAKE: begin
          if (cnt_q == WAKE_CYC) begin
            rxa_oe_q <= 1'b0;
            st_q <= ST_IDLE;
          end
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end
  assign pins.rd_n = rd_n_q;
  assign pins.wr = wr_q;
  assign pins.host_d_o = dq;
  assign pins.host_d_oe = doe_q;
  assign pins.host_rxa_o = 1'b0;
  assign pins.host_rxa_oe = rxa_oe_q;
  assign rd_data = rdd_q;
  assign rd_valid = rdv_q;
  assign wr_ready = (st_q == ST_IDLE) & ~txr_s_q[1] & ~rst;
  assign wake_busy = st_q == ST_WAKE;
endmodule
`default_nettype wire

// >>> upf_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module upf_assertions (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // pin levels
  input wire logic rd_n,
  input wire logic wr,
  input wire logic rx_avail_n,
  input wire logic tx_room_n,
  input wire logic dev_d_oe,
  input wire logic tx_room_n_oe,
  input wire logic rx_avail_n_oe,
  input wire logic power_enable_n,
  input wire logic pull_down
);
  // one domain
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  property p_rst_out; $past(rst) |-> !tx_room_n_oe && !rx_avail_n_oe && power_enable_n; endproperty
  a_rst_out: assert property (p_rst_out) else $error("status not released in reset");
  property p_bus_free; rd_n [*6] |-> !dev_d_oe; endproperty
  a_bus_free: assert property (p_bus_free) else $error("bus driven with read high");
  property p_bus_on; $fell(rd_n) && !rx_avail_n |-> ##[2:5] dev_d_oe; endproperty
  a_bus_on: assert property (p_bus_on) else $error("bus not driven on read");
  property p_bus_hold; !rd_n [*6] |-> dev_d_oe; endproperty
  a_bus_hold: assert property (p_bus_hold) else $error("bus dropped while read low");
  property p_avail_hi; !rd_n [*6] |-> rx_avail_n; endproperty
  a_avail_hi: assert property (p_avail_hi) else $error("available low during read");
  property p_room_busy; $rose(wr) |-> ##[1:5] tx_room_n; endproperty
  a_room_busy: assert property (p_room_busy) else $error("room flag kept low in write");
  property p_wake_in; $fell(rx_avail_n_oe) |-> power_enable_n; endproperty
  a_wake_in: assert property (p_wake_in) else $error("pin turned input while powered");
  property p_pull; !power_enable_n && $past(!power_enable_n) |-> !pull_down; endproperty
  a_pull: assert property (p_pull) else $error("pull-down while powered");
  // main scenarios
  c_read: cover property ($fell(rd_n));
  c_write: cover property ($fell(wr));
  c_wake: cover property ($fell(rx_avail_n_oe));
endmodule
`default_nettype wire

// >>> usb_parallel_fifo_port_tb.sv
`timescale 1ns/1ps
`default_nettype none
module usb_parallel_fifo_port_tb;
  // ****************************************
  // stimulus and observed signals
  // ****************************************
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] usb_rx_data = 8'h00;
  logic usb_rx_valid = 1'b0;
  logic usb_tx_ready = 1'b1;
  logic usb_configured = 1'b0;
  logic usb_suspended = 1'b0;
  logic opt_remote_wakeup = 1'b0;
  logic opt_suspend_pulldown = 1'b0;
  logic [7:0] wr_data = 8'h00;
  logic wr_valid = 1'b0;
  logic rd_req = 1'b0;
  logic wake_req = 1'b0;
  wire logic usb_rx_ready, usb_tx_valid, usb_resume_req, wr_ready, rd_valid, wake_busy;
  wire logic [7:0] usb_tx_data, rd_data;
  logic [7:0] txq[$];
  logic [7:0] got;
  int num_errors = 0;
  int checks = 0;
  int n;
  // 50 MHz clock
  always #10 sys_clk = ~sys_clk;
  // ****************************************
  // the two ends and the checker
  // ****************************************
  upf_if pins_if ();
  upf_dev #(.WAKE_CYC(50)) upf_dev_i (.sys_clk(sys_clk), .rst(rst), .pins(pins_if.dev),
    .usb_rx_data(usb_rx_data), .usb_rx_valid(usb_rx_valid), .usb_rx_ready(usb_rx_ready),
    .usb_tx_data(usb_tx_data), .usb_tx_valid(usb_tx_valid), .usb_tx_ready(usb_tx_ready),
    .usb_configured(usb_configured), .usb_suspended(usb_suspended), .opt_remote_wakeup(opt_remote_wakeup),
    .opt_suspend_pulldown(opt_suspend_pulldown), .usb_resume_req(usb_resume_req));
  upf_host #(.WAKE_CYC(50)) upf_host_i (.sys_clk(sys_clk), .rst(rst), .pins(pins_if.host),
    .wr_data(wr_data), .wr_valid(wr_valid), .wr_ready(wr_ready), .rd_req(rd_req), .rd_data(rd_data),
    .rd_valid(rd_valid), .wake_req(wake_req), .wake_busy(wake_busy));
  upf_assertions upf_assertions_i (.sys_clk(sys_clk), .rst(rst), .rd_n(pins_if.rd_n), .wr(pins_if.wr),
    .rx_avail_n(pins_if.rx_avail_n), .tx_room_n(pins_if.tx_room_n), .dev_d_oe(pins_if.dev_d_oe),
    .tx_room_n_oe(pins_if.tx_room_n_oe), .rx_avail_n_oe(pins_if.rx_avail_n_oe),
    .power_enable_n(pins_if.power_enable_n), .pull_down(pins_if.pull_down));
  // collect bytes leaving toward usb, sampled where settled
  always @(negedge sys_clk) begin
    if (usb_tx_valid && usb_tx_ready) begin
      txq.push_back(usb_tx_data);
    end
  end
  // ****************************************
  // helpers
  // ****************************************
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_rx();
    chk({7'h00, usb_rx_ready}, 8'h01);
    usb_rx_valid = 1'b1;
    for (int i = 0; i < 3; i++) begin
      usb_rx_data = 8'ha0 + 8'(i);
      for (n = 0; usb_rx_ready !== 1'b1 && n < 200; n++) @(negedge sys_clk);
      @(negedge sys_clk);
    end
    usb_rx_valid = 1'b0;
    repeat (6) @(negedge sys_clk);
    chk({7'h00, pins_if.rx_avail_n}, 8'h00);
    for (int i = 0; i < 3; i++) begin
      rd_req = 1'b1;
      for (n = 0; rd_valid !== 1'b1 && n < 200; n++) @(negedge sys_clk);
      got = rd_data;
      rd_req = 1'b0;
      chk(got, 8'ha0 + 8'(i));
      @(negedge sys_clk);
    end
    repeat (10) @(negedge sys_clk);
    chk({7'h00, pins_if.rx_avail_n}, 8'h01);
    $display("receive test done");
  endtask
  task automatic t_tx();
    chk({7'h00, pins_if.tx_room_n}, 8'h00);
    wr_valid = 1'b1;
    for (int i = 0; i < 3; i++) begin
      wr_data = 8'h5a ^ 8'(i * 97);
      for (n = 0; wr_ready !== 1'b1 && n < 200; n++) @(negedge sys_clk);
      @(negedge sys_clk);
    end
    wr_valid = 1'b0;
    repeat (60) @(negedge sys_clk);
    chk(8'(txq.size()), 8'h03);
    for (int i = 0; i < 3 && txq.size() > 0; i++) begin
      chk(txq.pop_front(), 8'h5a ^ 8'(i * 97));
    end
    $display("transmit test done");
  endtask
  task automatic t_suspend();
    opt_remote_wakeup = 1'b1;
    opt_suspend_pulldown = 1'b1;
    usb_suspended = 1'b1;
    repeat (8) @(negedge sys_clk);
    chk({7'h00, pins_if.power_enable_n}, 8'h01);
    chk({7'h00, pins_if.pull_down}, 8'h01);
    chk({7'h00, pins_if.rx_avail_n_oe}, 8'h00);
    wake_req = 1'b1;
    for (n = 0; wake_busy !== 1'b1 && n < 20; n++) @(negedge sys_clk);
    wake_req = 1'b0;
    for (n = 0; usb_resume_req !== 1'b1 && n < 200; n++) @(negedge sys_clk);
    chk({7'h00, n >= 50 && n < 200}, 8'h01);
    usb_suspended = 1'b0;
    repeat (8) @(negedge sys_clk);
    chk({6'h00, pins_if.pull_down, pins_if.power_enable_n}, 8'h00);
    $display("suspend test done");
  endtask
  // watchdog
  initial begin
    repeat (20000) @(posedge sys_clk);
    num_errors++;
    $display("BAD %0t watchdog expired", $time);
    report_and_stop();
  end
  // main sequence
  initial begin
    repeat (20) @(negedge sys_clk);
    chk({5'h00, pins_if.tx_room_n_oe, pins_if.rx_avail_n_oe, pins_if.power_enable_n}, 8'h01);
    rst = 1'b0;
    usb_configured = 1'b1;
    repeat (8) @(negedge sys_clk);
    chk({7'h00, pins_if.power_enable_n}, 8'h00);
    t_rx();
    t_tx();
    t_suspend();
    report_and_stop();
  end
endmodule
`default_nettype wire
